// ==== hw/bsrm_pkg.sv ====
package bsrm_pkg;

  // ----------------------------------------------------------------
  // Offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] BSRM_OFF_INDIRECT = 7'h00;
  localparam logic [6:0] BSRM_OFF_TIMER0   = 7'h01;
  localparam logic [6:0] BSRM_OFF_PCL      = 7'h02;
  localparam logic [6:0] BSRM_OFF_STATUS   = 7'h03;
  localparam logic [6:0] BSRM_OFF_POINTER  = 7'h04;
  localparam logic [6:0] BSRM_OFF_PORT_A   = 7'h05;
  localparam logic [6:0] BSRM_OFF_PORT_B   = 7'h06;
  localparam logic [6:0] BSRM_OFF_PORT_C   = 7'h07;
  localparam logic [6:0] BSRM_OFF_PC_HIGH_BUFFER   = 7'h0A;
  localparam logic [6:0] BSRM_OFF_INTCTL   = 7'h0B;
  localparam logic [6:0] BSRM_OFF_PIRQ     = 7'h0C;
  localparam logic [6:0] BSRM_OFF_T1L      = 7'h0E;
  localparam logic [6:0] BSRM_OFF_T1H      = 7'h0F;
  localparam logic [6:0] BSRM_OFF_T1CTL    = 7'h10;
  localparam logic [6:0] BSRM_OFF_T2       = 7'h11;
  localparam logic [6:0] BSRM_OFF_T2CTL    = 7'h12;
  localparam logic [6:0] BSRM_OFF_SERBUF   = 7'h13;
  localparam logic [6:0] BSRM_OFF_SERCTL   = 7'h14;
  localparam logic [6:0] BSRM_OFF_CCL      = 7'h15;
  localparam logic [6:0] BSRM_OFF_CCH      = 7'h16;
  localparam logic [6:0] BSRM_OFF_CCCTL    = 7'h17;
  localparam logic [6:0] BSRM_OFF_ANRES    = 7'h1E;
  localparam logic [6:0] BSRM_OFF_ANCTL    = 7'h1F;
  localparam logic [6:0] BSRM_GPR_BASE     = 7'h20;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int         BSRM_ST_IND_BANK  = 7;
  localparam int         BSRM_ST_BANK_HI   = 6;
  localparam int         BSRM_ST_BANK_LO   = 5;
  localparam int         BSRM_ST_TIMEOUT   = 4;
  localparam int         BSRM_ST_PWRDOWN   = 3;
  localparam logic [7:0] BSRM_ST_WR_MASK   = 8'hE7;
  localparam logic [7:0] BSRM_PIRQ_AN_BIT  = 8'h40;
  localparam int         BSRM_PC_HI_W      = 5;
  localparam int         BSRM_PC_W         = 13;

  // Readable bits per offset, writable too except status bits 4 and 3, index 31 down to 0
  localparam logic [31:0][7:0] BSRM_IMPL = {
    8'hFD, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'h3F,
    8'hFF, 8'hFF, 8'h00, 8'h4F, 8'hFF, 8'h1F, 8'h00, 8'h00,
    8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};

  // Bits kept through a pin or watchdog reset
  localparam logic [31:0][7:0] BSRM_KEEP = {
    8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h3F,
    8'hFF, 8'hFF, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
    8'hFF, 8'hFF, 8'h10, 8'hFF, 8'h07, 8'h00, 8'hFF, 8'h00};

  // Power-on and brown-out values; unknown bits are taken as zero
  localparam logic [31:0][7:0] BSRM_POR_VAL = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h00};

  // ----------------------------------------------------------------
  // Reset causes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BSRM_POWER_ON  = 2'b00,
    BSRM_BROWN_OUT = 2'b01,
    BSRM_EXT_PIN   = 2'b10,
    BSRM_WATCHDOG  = 2'b11
  } bsrm_cause_type;

endpackage : bsrm_pkg

// ==== hw/bsrm_register_map.sv ====
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Shared core registers decode identically in bank 0 and bank 1.
// - Upper program counter bits have no data address.
// - Five-bit high buffer is copied into counter bits 12:8 on a load.
// - Pin reset and watchdog reset use the non-power-up value column.
// - Any reset turns every port pin into an input, drivers off.
// - Port reset values are output latch contents, not pin levels.
// - Port write updates the latch; port read returns pin levels.
// - Unimplemented addresses and bits ignore writes and read zero.
// - Each register loads a power-up value or an other-reset value.
// - Unchanged bits hold, unknown bits are free, conditional bits follow cause.
// - Timer1 control clears on power-up only; timer2 control clears always.
// - Bank select 00 is bank 0, 01 bank 1; 10 and 11 unimplemented.
module bsrm_register_map
  import bsrm_pkg::*;
#(
  parameter bit HAS_ANALOG = 1'b1
) (
  input  wire logic                  mclk,
  input  wire logic                  srst,
  input  wire bsrm_cause_type        reset_cause,
  input  wire logic                  reset_timeout_bit,
  input  wire logic                  reset_powerdown_bit,
  input  wire logic [6:0]            bus_addr,
  input  wire logic [7:0]            bus_wdata,
  input  wire logic                  bus_wr,
  input  wire logic                  bus_rd,
  output logic      [7:0]            bus_rdata,
  output logic      [7:0]            mem_addr,
  output logic      [7:0]            mem_wdata,
  output logic                       mem_we,
  output logic                       mem_re,
  input  wire logic [7:0]            mem_rdata,
  input  wire logic                  core_pc_load,
  input  wire logic [7:0]            core_pc_low,
  input  wire logic                  core_pc_advance,
  output logic      [BSRM_PC_W-1:0]  pc_value,
  input  wire logic [7:0]            pirq_set,
  input  wire logic [2:0]            intctl_set,
  input  wire logic [5:0]            port_a_pin,
  input  wire logic [7:0]            port_b_pin,
  input  wire logic [7:0]            port_c_pin,
  input  wire logic [5:0]            port_a_dir,
  input  wire logic [7:0]            port_b_dir,
  input  wire logic [7:0]            port_c_dir,
  output logic      [5:0]            port_a_data,
  output logic      [7:0]            port_b_data,
  output logic      [7:0]            port_c_data,
  output logic      [5:0]            port_a_oe,
  output logic      [7:0]            port_b_oe,
  output logic      [7:0]            port_c_oe,
  output logic      [1:0]            bank_select,
  output logic                       indirect_bank_select,
  output logic      [7:0]            timer1_control,
  output logic      [7:0]            timer2_control,
  output logic      [7:0]            analog_control
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0][7:0]      sfr;
    logic [BSRM_PC_HI_W-1:0] pc_hi;
    logic [7:0]            rd_data;
    logic [21:0]           pin_s1;
    logic [21:0]           pin_s2;
    logic [21:0]           oe;
  } bsrm_state_type;

  bsrm_state_type state_reg;
  bsrm_state_type state_next;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Converter locations read zero on the variant without it
  function automatic logic [7:0] impl_mask(input logic [4:0] idx);
    logic [7:0] m;
    m = BSRM_IMPL[idx];
    if (!HAS_ANALOG) begin
      if (idx == BSRM_OFF_ANRES[4:0] || idx == BSRM_OFF_ANCTL[4:0]) begin
        m = 8'h00;
      end
      if (idx == BSRM_OFF_PIRQ[4:0]) begin
        m = m & ~BSRM_PIRQ_AN_BIT;
      end
    end
    return m;
  endfunction : impl_mask

  function automatic logic is_shared(input logic [6:0] off);
    return off == BSRM_OFF_INDIRECT || off == BSRM_OFF_PCL ||
           off == BSRM_OFF_STATUS   || off == BSRM_OFF_POINTER ||
           off == BSRM_OFF_PC_HIGH_BUFFER   || off == BSRM_OFF_INTCTL;
  endfunction : is_shared

  logic [7:0] status;
  logic [7:0] pointer;
  logic       ind_hit;
  logic [1:0] eff_bank;
  logic [6:0] eff_off;
  logic [4:0] idx;
  logic       hit_gpr;
  logic       hit_sfr;
  logic [7:0] rmask;
  logic [7:0] wmask;
  logic [7:0] pin_val;
  logic       is_port;
  logic [7:0] rd_val;
  logic       power_class;

  assign status   = state_reg.sfr[BSRM_OFF_STATUS[4:0]];
  assign pointer  = state_reg.sfr[BSRM_OFF_POINTER[4:0]];
  // The indirect port is no storage; the pointer names the target
  assign ind_hit  = bus_addr == BSRM_OFF_INDIRECT;
  // Reserved bank bits take part in decode, so software must keep them low
  assign eff_bank = ind_hit ? {status[BSRM_ST_IND_BANK], pointer[7]}
                            : status[BSRM_ST_BANK_HI:BSRM_ST_BANK_LO];
  assign eff_off  = ind_hit ? pointer[6:0] : bus_addr;
  assign idx      = eff_off[4:0];
  assign hit_gpr  = eff_off >= BSRM_GPR_BASE && !eff_bank[1];
  // Bank-1 registers that are not shared belong to another block
  assign hit_sfr  = eff_off < BSRM_GPR_BASE &&
                    (eff_bank == 2'b00 ||
                     (eff_bank == 2'b01 && is_shared(eff_off)));
  // Program counter high bits have no offset of their own
  assign rmask    = hit_sfr ? impl_mask(idx) : 8'h00;
  assign wmask    = rmask & ((eff_off == BSRM_OFF_STATUS) ? BSRM_ST_WR_MASK
                                                          : 8'hFF);
  assign is_port  = eff_off == BSRM_OFF_PORT_A || eff_off == BSRM_OFF_PORT_B ||
                    eff_off == BSRM_OFF_PORT_C;

  always_comb begin
    unique case (eff_off)
      BSRM_OFF_PORT_A: pin_val = {2'b00, state_reg.pin_s2[5:0]};
      BSRM_OFF_PORT_B: pin_val = state_reg.pin_s2[13:6];
      default:         pin_val = state_reg.pin_s2[21:14];
    endcase
  end

  // Ports read the pins, not the latch
  assign rd_val = hit_gpr ? mem_rdata
                : (is_port ? pin_val : state_reg.sfr[idx]) & rmask;

  // Pin and watchdog resets form the non-power-up class
  assign power_class = reset_cause == BSRM_POWER_ON ||
                       reset_cause == BSRM_BROWN_OUT;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next         = state_reg;
    state_next.pin_s1  = {port_c_pin, port_b_pin, port_a_pin};
    state_next.pin_s2  = state_reg.pin_s1;
    state_next.oe      = ~{port_c_dir, port_b_dir, port_a_dir};
    state_next.rd_data = bus_rd ? rd_val : 8'h00;

    // Register write; the port offsets land in the output latches
    if (bus_wr && hit_sfr) begin
      state_next.sfr[idx] = (bus_wdata & wmask) |
                            (state_reg.sfr[idx] & ~wmask);
    end

    // Any load of the low byte pulls the upper bits from the buffer
    if (bus_wr && hit_sfr && eff_off == BSRM_OFF_PCL) begin
      state_next.pc_hi = state_reg.sfr[BSRM_OFF_PC_HIGH_BUFFER[4:0]][4:0];
    end else if (core_pc_load) begin
      state_next.sfr[BSRM_OFF_PCL[4:0]] = core_pc_low;
      state_next.pc_hi = state_reg.sfr[BSRM_OFF_PC_HIGH_BUFFER[4:0]][4:0];
    end else if (core_pc_advance) begin
      {state_next.pc_hi, state_next.sfr[BSRM_OFF_PCL[4:0]]} =
        BSRM_PC_W'({state_reg.pc_hi, state_reg.sfr[BSRM_OFF_PCL[4:0]]} + 1'b1);
    end

    // Hardware set of a flag wins over a clearing write in the same cycle
    state_next.sfr[BSRM_OFF_PIRQ[4:0]] = state_next.sfr[BSRM_OFF_PIRQ[4:0]] |
      (pirq_set & impl_mask(BSRM_OFF_PIRQ[4:0]));
    state_next.sfr[BSRM_OFF_INTCTL[4:0]][2:0] =
      state_next.sfr[BSRM_OFF_INTCTL[4:0]][2:0] | intctl_set;

    if (srst) begin
      for (int i = 0; i < 32; i++) begin
        if (power_class) begin
          state_next.sfr[i] = BSRM_POR_VAL[i] & impl_mask(5'(i));
        end else begin
          state_next.sfr[i] = state_reg.sfr[i] & BSRM_KEEP[i] &
                              impl_mask(5'(i));
        end
      end
      // Timeout and power-down bits report the cause of a non-power reset
      if (!power_class) begin
        state_next.sfr[BSRM_OFF_STATUS[4:0]][BSRM_ST_TIMEOUT] =
          reset_timeout_bit;
        state_next.sfr[BSRM_OFF_STATUS[4:0]][BSRM_ST_PWRDOWN] =
          reset_powerdown_bit;
      end
      state_next.pc_hi   = '0;
      state_next.rd_data = 8'h00;
      state_next.pin_s1  = '0;
      state_next.pin_s2  = '0;
      state_next.oe      = '0;
    end
  end

  always_ff @(posedge mclk) begin
    state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus_rdata            = state_reg.rd_data;
  assign mem_addr             = {eff_bank[0], eff_off};
  assign mem_wdata            = bus_wdata;
  assign mem_we               = bus_wr && hit_gpr;
  assign mem_re               = bus_rd && hit_gpr;
  assign pc_value             = {state_reg.pc_hi, state_reg.sfr[BSRM_OFF_PCL[4:0]]};
  assign port_a_data          = state_reg.sfr[BSRM_OFF_PORT_A[4:0]][5:0];
  assign port_b_data          = state_reg.sfr[BSRM_OFF_PORT_B[4:0]];
  assign port_c_data          = state_reg.sfr[BSRM_OFF_PORT_C[4:0]];
  assign port_a_oe            = state_reg.oe[5:0];
  assign port_b_oe            = state_reg.oe[13:6];
  assign port_c_oe            = state_reg.oe[21:14];
  assign bank_select          = status[BSRM_ST_BANK_HI:BSRM_ST_BANK_LO];
  assign indirect_bank_select = status[BSRM_ST_IND_BANK];
  assign timer1_control       = state_reg.sfr[BSRM_OFF_T1CTL[4:0]];
  assign timer2_control       = state_reg.sfr[BSRM_OFF_T2CTL[4:0]];
  assign analog_control       = state_reg.sfr[BSRM_OFF_ANCTL[4:0]];

endmodule : bsrm_register_map

`default_nettype wire

// ==== tb/bsrm_register_map_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module bsrm_register_map_properties
  import bsrm_pkg::*;
(
  input wire logic                 mclk,
  input wire logic                 srst,
  input wire bsrm_cause_type       reset_cause,
  input wire logic [6:0]           bus_addr,
  input wire logic [7:0]           bus_wdata,
  input wire logic                 bus_wr,
  input wire logic                 bus_rd,
  input wire logic [7:0]           bus_rdata,
  input wire logic                 mem_re,
  input wire logic                 mem_we,
  input wire logic [7:0]           mem_addr,
  input wire logic [7:0]           mem_rdata,
  input wire logic                 core_pc_load,
  input wire logic                 core_pc_advance,
  input wire logic [BSRM_PC_W-1:0] pc_value,
  input wire logic [7:0]           port_c_dir,
  input wire logic [5:0]           port_a_data,
  input wire logic [5:0]           port_a_oe,
  input wire logic [7:0]           port_b_oe,
  input wire logic [7:0]           port_c_oe,
  input wire logic [1:0]           bank_select,
  input wire logic [7:0]           timer1_control,
  input wire logic [7:0]           timer2_control
);
  // --------------------------------------------------------------
  // Reset values; no disable here since reset is the cause
  // --------------------------------------------------------------
  a_oe_reset: assert property (@(posedge mclk) srst |=>
    (port_a_oe == 6'h00 && port_b_oe == 8'h00 && port_c_oe == 8'h00)) else $error("oe on");
  a_t2_clear: assert property (@(posedge mclk) srst |=> timer2_control == 8'h00)
    else $error("timer2 control kept");
  a_t1_power: assert property (@(posedge mclk) srst && !reset_cause[1] |=>
    timer1_control == 8'h00) else $error("timer1 control not cleared");
  a_t1_keep: assert property (@(posedge mclk) srst && reset_cause[1] |=>
    timer1_control == $past(timer1_control)) else $error("timer1 control lost");
  // --------------------------------------------------------------
  // Access behaviour
  // --------------------------------------------------------------
  a_oe_follow: assert property (@(posedge mclk) disable iff (srst) !$past(srst) |->
    port_c_oe == ~$past(port_c_dir)) else $error("oe does not follow direction");
  a_pcl_write: assert property (@(posedge mclk) disable iff (srst)
    bus_wr && bus_addr == BSRM_OFF_PCL && !bank_select[1] |=> pc_value[7:0] == $past(bus_wdata))
    else $error("counter low not loaded");
  a_pc_step: assert property (@(posedge mclk) disable iff (srst)
    !bus_wr && !core_pc_load && core_pc_advance |=> pc_value == $past(pc_value) + 13'h0001)
    else $error("counter did not step");
  a_port_latch: assert property (@(posedge mclk) disable iff (srst)
    bus_wr && bus_addr == BSRM_OFF_PORT_A && bank_select == 2'b00 |=>
    port_a_data == $past(bus_wdata[5:0])) else $error("port latch not written");
  a_bank_write: assert property (@(posedge mclk) disable iff (srst)
    bus_wr && bus_addr == BSRM_OFF_STATUS && !bank_select[1] |=>
    bank_select == $past(bus_wdata[6:5])) else $error("bank select not written");
  a_ind_read: assert property (@(posedge mclk) disable iff (srst)
    bus_rd && bus_addr == BSRM_OFF_INDIRECT && mem_re |=>
    bus_rdata == $past(mem_rdata)) else $error("indirect read wrong");
  a_gpr_route: assert property (@(posedge mclk) disable iff (srst)
    (bus_wr || bus_rd) && bus_addr >= BSRM_GPR_BASE && !bank_select[1] |->
    mem_we == bus_wr && mem_re == bus_rd && mem_addr == {bank_select[0], bus_addr})
    else $error("general register access misrouted");
endmodule : bsrm_register_map_properties

bind bsrm_register_map bsrm_register_map_properties u_props (.*);
`default_nettype wire

// ==== tb/bsrm_register_map_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module bsrm_register_map_tb
  import bsrm_pkg::*;
;
  logic mclk, srst, bus_wr, bus_rd, mem_we, mem_re, core_pc_load, core_pc_advance;
  logic reset_timeout_bit, reset_powerdown_bit, indirect_bank_select;
  bsrm_cause_type reset_cause;
  logic [6:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, mem_addr, mem_wdata, mem_rdata, core_pc_low, pirq_set;
  logic [7:0] port_b_pin, port_c_pin, port_b_dir, port_c_dir, port_b_data, port_c_data;
  logic [7:0] port_b_oe, port_c_oe, timer1_control, timer2_control, analog_control, d;
  logic [5:0] port_a_pin, port_a_dir, port_a_data, port_a_oe;
  logic [2:0] intctl_set;
  logic [1:0] bank_select;
  logic [BSRM_PC_W-1:0] pc_value;
  logic [31:0] seed = 32'h00012EA4, dir_s = 32'h00012EA4;
  int fails = 0, compares = 0;

  bsrm_register_map u_dut (.*);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // Pin and watchdog resets load cause bits, keep flags 2:0
  function automatic logic [7:0] stat_exp(input logic pin, input logic [2:0] low);
    return pin ? {3'b000, 1'b1, 1'b0, low} : 8'h18;
  endfunction : stat_exp
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge mclk); bus_wr <= 1'b1; bus_addr <= a; bus_wdata <= v;
    @(posedge mclk); bus_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [6:0] a);
    @(posedge mclk); bus_rd <= 1'b1; bus_addr <= a;
    @(posedge mclk); bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask : rd
  task automatic rst(input bsrm_cause_type c);
    @(posedge mclk); srst <= 1'b1; reset_cause <= c;
    @(posedge mclk); srst <= 1'b0;
  endtask : rst
  task automatic summarize;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // Clock, direction stimulus, watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    dir_s <= lfsr_next(dir_s);
    {port_c_dir, port_b_dir, port_a_dir} <= dir_s[21:0];
  end
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {srst, bus_wr, bus_rd, core_pc_load, core_pc_advance} = 5'b10000;
    {bus_addr, bus_wdata, mem_rdata, core_pc_low, pirq_set, intctl_set} = '0;
    {port_a_pin, port_b_pin, port_c_pin, reset_powerdown_bit} = '0;
    reset_timeout_bit = 1'b1;
    reset_cause = BSRM_POWER_ON;
    repeat (4) @(posedge mclk);
    #1 check({port_a_oe, port_b_oe}, 16'h0000);
    check(port_c_oe, 16'h0000);
    srst <= 1'b0;
    rd(BSRM_OFF_STATUS); check(d, 8'h18);
    rd(BSRM_OFF_PC_HIGH_BUFFER); check(d, 8'h00);
    for (int a = 1; a < 32; a++) if (!(a inside {2, 3, 5, 6, 7})) begin
      seed = lfsr_next(seed);
      wr(a[6:0], seed[7:0]);
      rd(a[6:0]); check(d, seed[7:0] & BSRM_IMPL[a]);
    end
    for (int c = 0; c < 4; c++) begin
      wr(BSRM_OFF_STATUS, 8'h07); wr(BSRM_OFF_T1CTL, 8'h35);
      rst(bsrm_cause_type'(c));
      #1 check(timer1_control, c[1] ? 8'h35 : 8'h00);
      check(timer2_control, 8'h00);
      rd(BSRM_OFF_STATUS); check(d, stat_exp(c[1], 3'h7));
    end
    check(indirect_bank_select, 1'b0);
    check(analog_control, 8'h00);
    wr(BSRM_OFF_STATUS, 8'h20); #1 check(bank_select, 2'b01);
    wr(BSRM_OFF_PC_HIGH_BUFFER, 8'h15); rd(BSRM_OFF_PC_HIGH_BUFFER); check(d, 8'h15);
    rd(BSRM_OFF_T2CTL); check(d, 8'h00);
    wr(BSRM_OFF_STATUS, 8'h00);
    wr(BSRM_OFF_PC_HIGH_BUFFER, 8'h1B); wr(BSRM_OFF_PCL, 8'h34);
    #1 check(pc_value, 13'h1B34);
    @(posedge mclk); core_pc_advance <= 1'b1;
    @(posedge mclk); core_pc_advance <= 1'b0;
    #1 check(pc_value, 13'h1B35);
    @(posedge mclk); core_pc_load <= 1'b1; core_pc_low <= 8'h56;
    @(posedge mclk); core_pc_load <= 1'b0;
    #1 check(pc_value, 13'h1B56);
    seed = lfsr_next(seed);
    wr(BSRM_OFF_PORT_A, seed[7:0] | 8'h10); #1 check(port_a_data, seed[5:0] | 6'h10);
    port_b_pin <= seed[15:8];
    repeat (4) @(posedge mclk);
    rd(BSRM_OFF_PORT_B); check(d, seed[15:8]);
    rst(BSRM_EXT_PIN); #1 check(port_a_data, 6'h10);
    wr(BSRM_OFF_POINTER, 8'h25); mem_rdata <= seed[23:16];
    rd(BSRM_OFF_INDIRECT); check(d, seed[23:16]);
    wr(7'h45, 8'h3C); rd(7'h45); check(d, seed[23:16]);
    wr(BSRM_OFF_PORT_C, seed[31:24]); #1 check(port_c_data, seed[31:24]);
    wr(BSRM_OFF_PORT_B, seed[7:0]); #1 check(port_b_data, seed[7:0]);
    // Flag set and clearing write in one cycle: the set must win
    pirq_set <= 8'hFF; intctl_set <= 3'h7;
    wr(BSRM_OFF_PIRQ, 8'h00); pirq_set <= 8'h00; intctl_set <= 3'h0;
    rd(BSRM_OFF_PIRQ); check(d, 8'h4F);
    rd(BSRM_OFF_INTCTL); check(d, 8'h07);
    summarize();
  end
endmodule : bsrm_register_map_tb
`default_nettype wire
